// File: design/flash_checker_regs.vh
// Register map, field positions, reset values and timing for the flash checker
`ifndef FLASH_CHECKER_REGS_VH
`define FLASH_CHECKER_REGS_VH
`define SCAN_CONTROL_OFF 12'h000
`define SCAN_SOURCE_SELECT_OFF 12'h004
`define SCAN_STATE_OFF 12'h008
`define CTRL_ENABLE_BIT 0
`define CTRL_IRQEN_BIT 1
`define CTRL_RESET_BIT 7
`define STATE_BUSY_BIT 0
`define STATE_PASS_BIT 1
`define SCAN_CONTROL_RST 8'h00
`define SCAN_SOURCE_SELECT_RST 8'h00
`define SCAN_STATE_RST 8'h02
`define REGION_WHOLE 2'h0
`define REGION_BOOT_CODE 2'h1
`define REGION_BOOT 2'h2
`define CRC_INIT 16'hffff
`define CRC_POLY 16'h1021
`define FETCH_PERIOD 2'h3
`define START_DELAY 2'h3
`define SECTION_PAGE 8
`endif

// File: design/crc16_byte.v
// CRC-16-CCITT update for one byte, most significant bit first
`timescale 1ns/1ps
`default_nettype none
`include "flash_checker_regs.vh"
module crc16_byte (
  input wire [15:0] crc_in, // Running remainder
  input wire [7:0] data, // Byte to absorb
  output reg [15:0] crc_out // Updated remainder
);
  integer i;
  reg fb;
  always @* begin
    crc_out = crc_in;
    fb = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      fb = crc_out[15] ^ data[i];
      crc_out = {crc_out[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    end
  end
endmodule // crc16_byte
`default_nettype wire

// File: design/fetch_pacer.v
// Enable pulse every third clock for flash word fetches
`timescale 1ns/1ps
`default_nettype none
`include "flash_checker_regs.vh"
module fetch_pacer (
  input wire pclk, // Clock
  input wire presetn, // Async reset, low
  input wire run, // Pacing active
  output reg tick // One-cycle fetch enable
);
  reg [1:0] cnt_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 2'h0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 2'h0;
      tick <= 1'b0;
    end else if (cnt_reg == `FETCH_PERIOD - 2'h1) begin
      cnt_reg <= 2'h0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      tick <= 1'b0;
    end
  end
endmodule // fetch_pacer
`default_nettype wire

// File: design/flash_checker.v
// Flash section CRC scan checker with APB registers and flash fetch port
//
// Function
// - Hold flash priority, stall CPU during check
// - Fetch one 16-bit word every third clock
// - Failed check clears the pass flag
// - Failure interrupt enable sticks until system reset
// - Fail with enable raises sticky nmi request
// - Nmi ignores global interrupt enable
// - Halt in sleep, resume on wake
// - Pending check runs right after wake
// - After nmi, control writes ignored
// - Source select locked while busy or nmi
// - Reset strobe clears registers one cycle later
// - Strobe gated by busy when interrupt enable set
// - Interrupt enable survives strobe, set only when idle
// - Writing enable one starts a new check
// - Clearing enable lets current check finish
// - Boot-time check reflected in enable and source
// - Source field selects scanned region
// - Status resets 0x02, pass flag behaviour
// - Busy high for whole check
// - Remainder starts 0xffff, CCITT polynomial
// - Bytes ascending, msb first
// - Check begins three cycles after enable
`timescale 1ns/1ps
`default_nettype none
`include "flash_checker_regs.vh"
module flash_checker (
  input wire pclk, // Clock, 100 MHz
  input wire presetn, // Async system reset, low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  input wire cpu_sleep, // CPU in a sleep mode
  input wire [7:0] boot_end_fuse, // Boot section end, 256-byte pages
  input wire [7:0] code_end_fuse, // Code section end, 256-byte pages
  input wire [15:0] last_memory_address, // Last flash byte address
  input wire boot_scan_en, // Check requested at reset init
  input wire [1:0] boot_scan_region, // Region for reset-init check
  output reg flash_req, // Priority flash read strobe
  output reg [15:0] flash_addr, // Word-aligned byte address
  input wire [15:0] flash_rdata, // Word read, valid next cycle
  output reg cpu_stall, // Stall request to CPU
  output reg nmi_req // Non-maskable interrupt request
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SCAN = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [1:0] state_reg;
  reg enable_reg;
  reg irqen_reg;
  reg [1:0] region_reg;
  reg busy_reg;
  reg pass_reg;
  reg clr_pend_reg;
  reg [1:0] delay_reg;
  reg [15:0] crc_reg;
  reg [15:0] addr_reg;
  reg [15:0] end_reg;
  reg data_valid_reg;
  reg last_reg;
  reg boot_init_reg;
  reg start_pend_reg;
  reg sleep_s1_reg;
  reg sleep_s2_reg;
  wire [15:0] crc_mid;
  wire [15:0] crc_new;
  wire tick;
  wire wr_access;
  wire rd_access;
  wire ctrl_wr;
  wire src_wr;
  wire strobe;
  wire go;

  // Last byte address of the selected region
  function [15:0] section_end;
    input [1:0] sel;
    input [7:0] boot_f;
    input [7:0] code_f;
    input [15:0] last_a;
    begin
      case (sel)
        `REGION_BOOT: section_end = {boot_f, 8'h00} - 16'h0001;
        `REGION_BOOT_CODE: section_end = {code_f, 8'h00} - 16'h0001;
        default: section_end = last_a;
      endcase
    end
  endfunction

  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign ctrl_wr = wr_access && (paddr == `SCAN_CONTROL_OFF) && !nmi_req;
  assign src_wr = wr_access && (paddr == `SCAN_SOURCE_SELECT_OFF) && !nmi_req && !busy_reg;
  assign strobe = ctrl_wr && pwdata[`CTRL_RESET_BIT] && (!irqen_reg || !busy_reg);
  assign go = ctrl_wr && pwdata[`CTRL_ENABLE_BIT] && !strobe;

  // High byte first at even address, then low byte
  crc16_byte crc_hi (
    .crc_in(crc_reg),
    .data(flash_rdata[15:8]),
    .crc_out(crc_mid)
  );
  crc16_byte crc_lo (
    .crc_in(crc_mid),
    .data(flash_rdata[7:0]),
    .crc_out(crc_new)
  );

  fetch_pacer pacer (
    .pclk(pclk),
    .presetn(presetn),
    .run((state_reg == ST_SCAN) && !sleep_s2_reg && !last_reg),
    .tick(tick)
  );

  // Sleep level from the power controller
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
    end else begin
      sleep_s1_reg <= cpu_sleep;
      sleep_s2_reg <= sleep_s1_reg;
    end
  end

  // APB answer, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SCAN_CONTROL_OFF: prdata <= {30'h0, irqen_reg, enable_reg};
          `SCAN_SOURCE_SELECT_OFF: prdata <= {30'h0, region_reg};
          `SCAN_STATE_OFF: prdata <= {30'h0, pass_reg && !busy_reg, busy_reg};
          default: pslverr <= 1'b1;
        endcase
      end else if (psel && !penable && pwrite) begin
        pslverr <= (paddr != `SCAN_CONTROL_OFF) && (paddr != `SCAN_SOURCE_SELECT_OFF) &&
          (paddr != `SCAN_STATE_OFF);
      end
    end
  end

  // Control, status and scan engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      enable_reg <= 1'b0;
      irqen_reg <= 1'b0;
      region_reg <= `REGION_WHOLE;
      busy_reg <= 1'b0;
      pass_reg <= 1'b1;
      clr_pend_reg <= 1'b0;
      delay_reg <= 2'h0;
      crc_reg <= `CRC_INIT;
      addr_reg <= 16'h0000;
      end_reg <= 16'h0000;
      data_valid_reg <= 1'b0;
      last_reg <= 1'b0;
      boot_init_reg <= 1'b1;
      start_pend_reg <= 1'b0;
      flash_req <= 1'b0;
      flash_addr <= 16'h0000;
      cpu_stall <= 1'b0;
      nmi_req <= 1'b0;
    end else begin
      flash_req <= 1'b0;
      data_valid_reg <= flash_req;
      boot_init_reg <= 1'b0;
      if (boot_init_reg && boot_scan_en) begin
        enable_reg <= 1'b1;
        region_reg <= boot_scan_region;
        start_pend_reg <= 1'b1;
      end
      if (clr_pend_reg) begin
        clr_pend_reg <= 1'b0;
        enable_reg <= 1'b0;
        region_reg <= `REGION_WHOLE;
        busy_reg <= 1'b0;
        pass_reg <= 1'b1;
        state_reg <= ST_IDLE;
        cpu_stall <= 1'b0;
        last_reg <= 1'b0;
        start_pend_reg <= 1'b0;
      end else begin
        if (strobe) begin
          clr_pend_reg <= 1'b1;
        end
        if (ctrl_wr && !strobe) begin
          enable_reg <= pwdata[`CTRL_ENABLE_BIT];
          if (pwdata[`CTRL_IRQEN_BIT] && !busy_reg) begin
            irqen_reg <= 1'b1;
          end
        end
        if (src_wr) begin
          region_reg <= pwdata[1:0];
        end
        if (go) begin
          start_pend_reg <= 1'b1;
        end
        case (state_reg)
          ST_IDLE: begin
            if ((go || start_pend_reg) && !sleep_s2_reg && region_reg != 2'h3) begin
              start_pend_reg <= 1'b0;
              state_reg <= ST_WAIT;
              busy_reg <= 1'b1;
              pass_reg <= 1'b0;
              delay_reg <= `START_DELAY - 2'h1;
            end
          end
          ST_WAIT: begin
            if (delay_reg == 2'h0) begin
              state_reg <= ST_SCAN;
              crc_reg <= `CRC_INIT;
              addr_reg <= 16'h0000;
              end_reg <= section_end(region_reg, boot_end_fuse, code_end_fuse,
                last_memory_address);
              last_reg <= 1'b0;
              cpu_stall <= 1'b1;
            end else begin
              delay_reg <= delay_reg - 2'h1;
            end
          end
          ST_SCAN: begin
            if (tick && !last_reg) begin
              flash_req <= 1'b1;
              flash_addr <= addr_reg;
              addr_reg <= addr_reg + 16'h0002;
              last_reg <= (addr_reg + 16'h0001) >= end_reg;
            end
            if (data_valid_reg) begin
              crc_reg <= crc_new;
              if (last_reg) begin
                state_reg <= ST_DONE;
              end
            end
          end
          ST_DONE: begin
            busy_reg <= 1'b0;
            cpu_stall <= 1'b0;
            last_reg <= 1'b0;
            state_reg <= ST_IDLE;
            if (crc_reg == 16'h0000) begin
              pass_reg <= 1'b1;
            end else begin
              pass_reg <= 1'b0;
              if (irqen_reg) begin
                nmi_req <= 1'b1;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // flash_checker
`default_nettype wire

// File: verif/flash_checker_props.sv
// Port assertions for the flash checker
`timescale 1ns/1ps
`default_nettype none
module flash_checker_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic cpu_sleep, // Sleep
  input wire logic flash_req, // Fetch
  input wire logic cpu_stall, // Stall
  input wire logic nmi_req // Nmi
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_done = psel && penable && pready && !pwrite;
  AST_NMI_HOLD: assert property (nmi_req |=> nmi_req)
    else $error("nmi request dropped");
  AST_FETCH_GAP: assert property (flash_req |=> !flash_req [*2])
    else $error("fetch too soon");
  AST_FETCH_PACE: assert property ((cpu_stall && !cpu_sleep) [*8] |->
    flash_req || $past(flash_req) || $past(flash_req, 2))
    else $error("fetch missing");
  AST_FETCH_STALL: assert property (flash_req |-> cpu_stall)
    else $error("fetch without stall");
  AST_FETCH_START: assert property ($rose(cpu_stall) |-> ##[0:4] flash_req)
    else $error("scan did not fetch");
  AST_SLEEP_HALT: assert property (cpu_sleep [*6] |-> !flash_req)
    else $error("fetch in sleep");
  AST_UNUSED_ZERO: assert property (rd_done && paddr <= 12'h008 |->
    prdata[31:8] == 24'h000000 && prdata[6:2] == 5'h00)
    else $error("unused bits set");
  AST_BUSY_READ: assert property (rd_done && paddr == 12'h008 && $past(cpu_stall) |->
    prdata[1:0] == 2'h1)
    else $error("status wrong while busy");
  AST_NMI_FAIL: assert property (rd_done && paddr == 12'h008 && $past(nmi_req) |-> !prdata[1])
    else $error("pass flag set after nmi");
  AST_NMI_CAUSE: assert property ($rose(nmi_req) |->
    $past(cpu_stall) || $past(cpu_stall, 2) || $past(cpu_stall, 3))
    else $error("nmi without scan");
  cover property ($rose(nmi_req));
  cover property (cpu_sleep && cpu_stall);
  cover property (rd_done && paddr == 12'h008 && $past(cpu_stall));
endmodule // flash_checker_props
bind flash_checker flash_checker_props flash_checker_props_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .cpu_sleep, .flash_req, .cpu_stall, .nmi_req);
`default_nettype wire

// File: verif/flash_model.sv
// Flash memory answering priority word fetches
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input wire logic pclk, // Clock
  input wire logic flash_req, // Fetch strobe
  input wire logic [15:0] flash_addr, // Even byte address
  output logic [15:0] flash_rdata // Word, even byte high
);
  logic [7:0] mem [0:767];
  int reqs = 0;
  initial flash_rdata = 16'h0000;
  // Data only valid after a fetch
  always @(posedge pclk) begin
    if (flash_req) begin
      flash_rdata <= {mem[flash_addr], mem[flash_addr + 16'h0001]};
      reqs <= reqs + 1;
    end else begin
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule // flash_model
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the flash checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_sleep = 0, er;
  logic boot_scan_en = 0;
  logic [1:0] boot_scan_region = 2'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd, seed = 32'h0000ae39;
  logic pready, pslverr, flash_req, cpu_stall, nmi_req;
  logic [15:0] flash_addr, flash_rdata, c;
  int num_errors = 0, check_count = 0;
  always #5 pclk = ~pclk;
  flash_checker flash_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpu_sleep, .boot_end_fuse(8'h01), .code_end_fuse(8'h02),
    .last_memory_address(16'h02ff), .boot_scan_en, .boot_scan_region, .flash_req,
    .flash_addr, .flash_rdata, .cpu_stall, .nmi_req);
  flash_model flash_model_i (.pclk, .flash_req, .flash_addr, .flash_rdata);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] crc(int n);
    logic [15:0] r = 16'hffff;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--)
        r = {r[14:0], 1'b0} ^ ((r[15] ^ flash_model_i.mem[i][b]) ? 16'h1021 : 16'h0000);
    return r;
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) num_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    int n = 0;
    do begin
      apb(0, 12'h008, 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 1000);
    if (n == 1000) num_errors++;
  endtask
  task automatic scan(logic [1:0] r, logic [31:0] ce);
    int sz = 256 * (3 - r);
    int q = flash_model_i.reqs;
    apb(1, 12'h004, {30'h0, r});
    apb(1, 12'h000, ce);
    apb(0, 12'h008, 0);
    check("busy", rd, 32'h1);
    apb(1, 12'h004, 32'h3);
    apb(0, 12'h004, 0);
    check("source", rd, {30'h0, r});
    cpu_sleep <= 1'b1;
    repeat (40) @(posedge pclk);
    cpu_sleep <= 1'b0;
    wait_idle();
    check("status", rd, (crc(sz) == 0) ? 32'h2 : 32'h0);
    check("words", flash_model_i.reqs - q, sz / 2);
    apb(0, 12'h000, 0);
    check("control", rd, ce);
    check("nmi", nmi_req, ce[1] && crc(sz) != 0);
    $display("scan %0d done", r);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #300000;
    num_errors++;
    end_sim();
  end
  initial begin
    for (int i = 0; i < 768; i++) begin
      void'(xs());
      flash_model_i.mem[i] = seed[7:0];
    end
    for (int e = 256; e <= 768; e += 256) begin
      c = crc(e - 2);
      flash_model_i.mem[e - 2] = c[15:8];
      flash_model_i.mem[e - 1] = c[7:0];
    end
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    check("ctrl rst", rd, 32'h0);
    apb(0, 12'h004, 0);
    check("src rst", rd, 32'h0);
    apb(0, 12'h008, 0);
    check("status rst", rd, 32'h2);
    apb(0, 12'h00c, 0);
    check("unmapped", er, 32'h1);
    $display("reset test done");
    for (int r = 0; r < 3; r++) scan(r[1:0], 32'h1);
    apb(1, 12'h000, 32'h80);
    apb(0, 12'h000, 0);
    check("strobe ctrl", rd, 32'h0);
    apb(0, 12'h004, 0);
    check("strobe src", rd, 32'h0);
    flash_model_i.mem[5] = flash_model_i.mem[5] ^ 8'h01;
    apb(1, 12'h000, 32'h2);
    apb(1, 12'h000, 32'h80);
    apb(0, 12'h000, 0);
    check("irq kept", rd, 32'h2);
    scan(2'h2, 32'h3);
    apb(1, 12'h000, 32'h80);
    apb(0, 12'h000, 0);
    check("locked", rd, 32'h3);
    $display("fail test done");
    @(posedge pclk);
    presetn <= 1'b0;
    boot_scan_en <= 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check("nmi rst", nmi_req, 32'h0);
    apb(0, 12'h000, 0);
    check("boot ctrl", rd, 32'h1);
    apb(0, 12'h004, 0);
    check("boot src", rd, 32'h1);
    wait_idle();
    check("boot status", rd, (crc(512) == 0) ? 32'h2 : 32'h0);
    $display("boot test done");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
